// File: hdl/gpm_pin_function_mux.sv
module gpm_pin_function_mux #(
  parameter int ALARM_W = 4
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic [gpm_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [gpm_pkg::DATA_W-1:0] regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [gpm_pkg::DATA_W-1:0] regRdData,
  input  wire logic                    functionInputPin,
  output logic                         functionOutputPinO,
  output logic                         functionOutputPinOe,
  input  wire logic [ALARM_W-1:0]      alarmEvents,
  input  wire gpm_pkg::gpm_status_t    status,
  input  wire logic                    otherPulseGenReq,
  input  wire logic [2:0]              pulseGenMode,
  output gpm_pkg::gpm_req_t            request,
  output logic                         pulseGenLevelRun,
  output logic                         outputDriversMuted,
  output logic [ALARM_W-1:0]           alarmLatched,
  output gpm_pkg::gpm_inbuf_t          clkInBufCfg,
  output gpm_pkg::gpm_inbuf_t          syncInBufCfg
);
  import gpm_pkg::*;

  if (ALARM_W < 1 || ALARM_W > DATA_W)
  begin : g_bad_width
    $error("ALARM_W must be 1 to 8");
  end

  // ****************************************
  // register file
  // ****************************************
  logic [7:0]         scratch_q;
  gpm_inbuf_t         clkBuf_q;
  gpm_inbuf_t         syncBuf_q;
  logic [4:0]         inFn_q;
  logic [6:0]         outFn_q;
  logic [ALARM_W-1:0] alarm_q;
  logic               alarmClr;
  logic [7:0]         rdValue;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign alarmClr = regWr && hit(regAddr, OFS_ALARM_CLEAR) && regWrData[ALARM_CLR_BIT];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      scratch_q <= RST_SCRATCHPAD;
    else if (regWr && hit(regAddr, OFS_SCRATCHPAD))
      scratch_q <= regWrData;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clkBuf_q  <= RST_INBUF;
      syncBuf_q <= RST_INBUF;
    end
    else if (regWr && hit(regAddr, OFS_CLK_INBUF))
      clkBuf_q <= regWrData[INBUF_MSB:0];
    else if (regWr && hit(regAddr, OFS_SYNC_INBUF))
      syncBuf_q <= regWrData[INBUF_MSB:0];
  end

  // code changes while enabled are honoured but may glitch a request
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      inFn_q <= RST_IN_FN;
    else if (regWr && hit(regAddr, OFS_IN_FN_CTRL))
      inFn_q <= regWrData[IN_FN_CODE_MSB:0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      outFn_q <= RST_OUT_FN;
    else if (regWr && hit(regAddr, OFS_OUT_FN_CTRL))
      outFn_q <= regWrData[OUT_CODE_MSB:0];
  end

  // new events win over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      alarm_q <= '0;
    else
      alarm_q <= (alarm_q & ~{ALARM_W{alarmClr}}) | alarmEvents;
  end

  // spares and alarm_clear read as zero
  always_comb
  begin
    rdValue = 8'h00;
    case (regAddr)
      OFS_SCRATCHPAD:   rdValue = scratch_q;
      OFS_CLK_INBUF:    rdValue = {3'b000, clkBuf_q};
      OFS_SYNC_INBUF:   rdValue = {3'b000, syncBuf_q};
      OFS_ALARM_STATUS: rdValue = 8'(alarm_q);
      OFS_IN_FN_CTRL:   rdValue = {3'b000, inFn_q};
      OFS_OUT_FN_CTRL:  rdValue = {1'b0, outFn_q};
      default:          rdValue = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      regRdData <= 8'h00;
    else if (regRd)
      regRdData <= rdValue;
    else
      regRdData <= 8'h00;
  end

  assign alarmLatched = alarm_q;
  assign clkInBufCfg  = clkBuf_q;
  assign syncInBufCfg = syncBuf_q;

  // ****************************************
  // input pin functions
  // ****************************************
  logic       inEn;
  logic [3:0] inCode;
  gpm_req_t   lvl;
  gpm_req_t   lvlPrev_q;
  gpm_req_t   req_q;
  logic       pgenAll;

  assign inEn   = inFn_q[IN_FN_EN_BIT];
  assign inCode = inFn_q[IN_FN_CODE_MSB:IN_FN_CODE_LSB];

  function automatic logic inSel(input logic en, input logic [3:0] c,
                                 input gpm_in_fn_t f, input logic pin);
    inSel = en && (c == f) && pin;
  endfunction : inSel

  // reserved codes select nothing
  always_comb
  begin
    lvl.sleep    = inSel(inEn, inCode, IN_SLEEP, functionInputPin);
    lvl.mute     = inSel(inEn, inCode, IN_MUTE, functionInputPin);
    lvl.pulseGen = inSel(inEn, inCode, IN_PULSE, functionInputPin);
    lvl.reseed   = inSel(inEn, inCode, IN_RESEED, functionInputPin);
    lvl.restart  = inSel(inEn, inCode, IN_RESTART, functionInputPin);
    lvl.slip     = inSel(inEn, inCode, IN_SLIP, functionInputPin);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      lvlPrev_q <= '0;
    else
      lvlPrev_q <= lvl;
  end

  // levels pass as levels, edge-triggered requests become one-cycle pulses
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      req_q <= '0;
    else
    begin
      req_q.sleep    <= lvl.sleep;
      req_q.mute     <= lvl.mute;
      req_q.pulseGen <= pgenAll;
      req_q.reseed   <= lvl.reseed && !lvlPrev_q.reseed
                        && (status.syncFsmState == SYNC_FSM_DONE);
      req_q.restart  <= lvl.restart && !lvlPrev_q.restart;
      req_q.slip     <= lvl.slip && !lvlPrev_q.slip;
    end
  end

  assign pgenAll = lvl.pulseGen || otherPulseGenReq;

  // mute only gates drivers, no divider reset is issued
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      outputDriversMuted <= 1'b0;
    else
      outputDriversMuted <= lvl.mute;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pulseGenLevelRun <= 1'b0;
    else
      pulseGenLevelRun <= (pulseGenMode == PGEN_MODE_LEVEL) && pgenAll;
  end

  assign request = req_q;

  // ****************************************
  // output pin function
  // ****************************************
  logic [4:0] outCode;
  logic       outVal;
  logic       outO_q;
  logic       outOe_q;

  assign outCode = outFn_q[OUT_CODE_MSB:OUT_CODE_LSB];

  always_comb
  begin
    case (outCode)
      OUT_ALARM:      outVal = |alarm_q;
      OUT_READBACK:   outVal = status.serialReadbackData;
      OUT_NOT_SYNCED: outVal = status.notSyncedSinceReset;
      OUT_PHASE:      outVal = status.phaseStatus;
      OUT_SYNC_REQ:   outVal = status.syncReqStatus;
      OUT_FSM_BUSY:   outVal = status.fsmBusy;
      OUT_STATE0:     outVal = status.syncFsmState[0];
      OUT_STATE1:     outVal = status.syncFsmState[1];
      OUT_STATE2:     outVal = status.syncFsmState[2];
      OUT_STATE3:     outVal = status.syncFsmState[3];
      OUT_FORCE1:     outVal = 1'b1;
      OUT_FORCE0:     outVal = 1'b0;
      OUT_PGEN_REQ:   outVal = status.pulseGenReqStatus;
      default:        outVal = 1'b0;
    endcase
  end

  // independent of the input side, so both may be active at once
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      outO_q  <= 1'b0;
      outOe_q <= 1'b0;
    end
    else if (outFn_q[OUT_TYPE_BIT])
    begin
      outO_q  <= outVal;
      outOe_q <= outFn_q[OUT_EN_BIT];
    end
    else
    begin
      outO_q  <= 1'b0;
      outOe_q <= outFn_q[OUT_EN_BIT] && !outVal;
    end
  end

  assign functionOutputPinO  = outO_q;
  assign functionOutputPinOe = outOe_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  chk_alarm_clear: assert property (
    alarmClr && (alarmEvents == '0) |=> (alarmLatched == '0))
    else $error("alarm clear left a flag set");

  chk_scratch_echo: assert property (
    regWr && hit(regAddr, OFS_SCRATCHPAD) ##1 regRd && hit(regAddr, OFS_SCRATCHPAD)
    |=> regRdData == $past(regWrData, 2))
    else $error("scratchpad read differs from write");

  chk_inbuf_write: assert property (
    regWr && hit(regAddr, OFS_CLK_INBUF) |=> clkInBufCfg == $past(regWrData[4:0]))
    else $error("clock input buffer setting wrong");

  chk_sleep_mute: assert property (
    inEn && inCode == IN_MUTE && functionInputPin
    |=> request.mute && outputDriversMuted && !request.sleep)
    else $error("mute not raised");

  chk_reseed_gate: assert property (
    request.reseed |-> $past(status.syncFsmState) == SYNC_FSM_DONE
    && $past(lvl.reseed) && !$past(lvlPrev_q.reseed))
    else $error("reseed outside done state or edge");

  chk_slip_pulse: assert property (
    request.slip |=> !request.slip)
    else $error("slip request longer than one cycle");

  chk_force_high: assert property (
    outFn_q[OUT_EN_BIT] && outFn_q[OUT_TYPE_BIT] && outCode == OUT_FORCE1
    |=> functionOutputPinO && functionOutputPinOe)
    else $error("forced high not driven");

  chk_open_drain: assert property (
    !outFn_q[OUT_TYPE_BIT] |=> !functionOutputPinO)
    else $error("open-drain pin drove high");

  chk_state_bit: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_STATE2
    |=> functionOutputPinO == $past(status.syncFsmState[2]))
    else $error("sync state bit 2 not shown");

  chk_level_run: assert property (
    pulseGenMode == PGEN_MODE_LEVEL ##1 pulseGenMode == PGEN_MODE_LEVEL
    |-> pulseGenLevelRun == $past(pgenAll))
    else $error("level pulse run not following request");

  chk_sync_buf: assert property (
    regWr && hit(regAddr, OFS_SYNC_INBUF) |=> syncInBufCfg == $past(regWrData[4:0]))
    else $error("sync input buffer setting wrong");

  chk_sleep_level: assert property (
    inEn && inCode == IN_SLEEP && functionInputPin |=> request.sleep && !request.mute)
    else $error("sleep not raised");

  chk_pulse_req: assert property (
    otherPulseGenReq || (inEn && inCode == IN_PULSE && functionInputPin)
    |=> request.pulseGen)
    else $error("pulse generator request lost");

  chk_restart_pulse: assert property (
    request.restart |-> $past(inEn && inCode == IN_RESTART && functionInputPin))
    else $error("restart without its pin function");

  chk_both_ways: assert property (
    inEn && outFn_q[OUT_EN_BIT] && outFn_q[OUT_TYPE_BIT] |=> functionOutputPinOe)
    else $error("output driver dropped while input active");

  chk_alarm_out: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_ALARM
    |=> functionOutputPinO == $past(|alarm_q))
    else $error("alarm not shown on output pin");

  chk_readback_out: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_READBACK
    |=> functionOutputPinO == $past(status.serialReadbackData))
    else $error("readback data not shown");

  chk_not_synced: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_NOT_SYNCED
    |=> functionOutputPinO == $past(status.notSyncedSinceReset))
    else $error("sync history flag not shown");

  chk_phase_out: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_PHASE
    |=> functionOutputPinO == $past(status.phaseStatus))
    else $error("phase status not shown");

  chk_busy_out: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_FSM_BUSY
    |=> functionOutputPinO == $past(status.fsmBusy))
    else $error("channel busy not shown");

  chk_force_low: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_FORCE0 |=> !functionOutputPinO)
    else $error("forced low not driven");

  chk_pgen_status: assert property (
    outFn_q[OUT_TYPE_BIT] && outCode == OUT_PGEN_REQ
    |=> functionOutputPinO == $past(status.pulseGenReqStatus))
    else $error("pulse request status not shown");

  chk_push_pull_en: assert property (
    outFn_q[OUT_TYPE_BIT]
    |=> functionOutputPinOe == $past(outFn_q[OUT_EN_BIT]))
    else $error("push-pull enable not followed");

  chk_reseed_refused: assert property (
    status.syncFsmState != SYNC_FSM_DONE |=> !request.reseed)
    else $error("reseed taken outside done state");

  chk_mute_only: assert property (
    outputDriversMuted |-> request.mute && !request.restart && !request.sleep)
    else $error("mute touched more than the drivers");

  chk_alarm_set_wins: assert property (
    alarmClr && alarmEvents != '0
    |=> (alarmLatched & $past(alarmEvents)) == $past(alarmEvents))
    else $error("new alarm lost to a clear");

  chk_rd_idle: assert property (
    !regRd |=> regRdData == '0)
    else $error("read data outside its cycle");

  cov_reseed: cover property (request.reseed);
  cov_open_drain: cover property (functionOutputPinOe && !outFn_q[OUT_TYPE_BIT]);
  cov_alarm_clear: cover property (alarmClr && alarmLatched != '0);
  cov_both_ways: cover property (inEn && functionOutputPinOe);
  cov_slip: cover property (request.slip);

endmodule : gpm_pin_function_mux

// File: hdl/gpm_pkg.sv
// How it works
// - scratchpad stores and returns any 8-bit value, affecting nothing else
// - input buffer mode field bits 4..1: high-Z, LVPECL, ac, termination
// - enabled input pin with code 0010 forces sleep, 0011 mutes outputs
// - code 0100 makes the pin raise a shared pulse-generator request
// - code 0101 issues a reseed request, 0110 a divider and FSM restart
// - code 1000 issues a slip request to slip-sensitive divider channels
// - one pin may serve as input function and output function together
// - output code field bits 6..2; 00000 alarm, 00001 serial readback
// - output code 00010 shows sync not done since reset
// - output code 00011 shows clock output phase status
// - output code 00100 sync request status, 00101 channel FSM busy
// - output codes 01010 and 01011 force logic 1 and logic 0
// - output code 11001 shows pulse-generator request status
// - output control bit 1 driver type, 0 open-drain; bit 0 enables
// - reseed taken only on rising edge while resync FSM state is 0010
// - mute silences output drivers while dividers keep running
// - level pulse mode 000 runs the generator while the request is high
package gpm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_MODE_SPARE   = 8'h05;
  localparam logic [7:0] OFS_ALARM_CLEAR  = 8'h06;
  localparam logic [7:0] OFS_MISC_SPARE_A = 8'h07;
  localparam logic [7:0] OFS_SCRATCHPAD   = 8'h08;
  localparam logic [7:0] OFS_MISC_SPARE_B = 8'h09;
  localparam logic [7:0] OFS_CLK_INBUF    = 8'h0A;
  localparam logic [7:0] OFS_SYNC_INBUF   = 8'h0B;
  localparam logic [7:0] OFS_ALARM_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IN_FN_CTRL   = 8'h46;
  localparam logic [7:0] OFS_OUT_FN_CTRL  = 8'h50;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ALARM_CLR_BIT  = 0;
  localparam int INBUF_MSB      = 4;
  localparam int IN_FN_EN_BIT   = 0;
  localparam int IN_FN_CODE_LSB = 1;
  localparam int IN_FN_CODE_MSB = 4;
  localparam int OUT_EN_BIT     = 0;
  localparam int OUT_TYPE_BIT   = 1;
  localparam int OUT_CODE_LSB   = 2;
  localparam int OUT_CODE_MSB   = 6;
  localparam logic [7:0] RST_SCRATCHPAD = 8'h00;
  localparam logic [4:0] RST_INBUF      = 5'h00;
  localparam logic [4:0] RST_IN_FN      = 5'h00;
  localparam logic [6:0] RST_OUT_FN     = 7'h00;
  localparam logic [3:0] SYNC_FSM_DONE  = 4'h2;
  localparam logic [2:0] PGEN_MODE_LEVEL = 3'h0;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    IN_SLEEP = 4'b0010, IN_MUTE = 4'b0011, IN_PULSE = 4'b0100,
    IN_RESEED = 4'b0101, IN_RESTART = 4'b0110, IN_SLIP = 4'b1000
  } gpm_in_fn_t;
  typedef enum logic [4:0] {
    OUT_ALARM = 5'b00000, OUT_READBACK = 5'b00001, OUT_NOT_SYNCED = 5'b00010,
    OUT_PHASE = 5'b00011, OUT_SYNC_REQ = 5'b00100, OUT_FSM_BUSY = 5'b00101,
    OUT_STATE0 = 5'b00110, OUT_STATE1 = 5'b00111, OUT_STATE2 = 5'b01000,
    OUT_STATE3 = 5'b01001, OUT_FORCE1 = 5'b01010, OUT_FORCE0 = 5'b01011,
    OUT_PGEN_REQ = 5'b11001
  } gpm_out_fn_t;
  typedef struct packed {
    logic hiZ;
    logic lvpecl;
    logic acCouple;
    logic term100;
    logic enable;
  } gpm_inbuf_t;
  typedef struct packed {
    logic       serialReadbackData;
    logic       notSyncedSinceReset;
    logic       phaseStatus;
    logic       syncReqStatus;
    logic       fsmBusy;
    logic [3:0] syncFsmState;
    logic       pulseGenReqStatus;
  } gpm_status_t;
  typedef struct packed {
    logic sleep;
    logic mute;
    logic pulseGen;
    logic reseed;
    logic restart;
    logic slip;
  } gpm_req_t;
endpackage : gpm_pkg

// File: testbench/gp_pin_function_mux_test.sv
module gp_pin_function_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpm_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic              sys_clk;
  logic              rstn;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdData;
  logic              pinCmd;
  logic              functionInputPin;
  logic              functionOutputPinO;
  logic              functionOutputPinOe;
  logic              wireLevel;
  logic [3:0]        alarmEvents;
  gpm_status_t       status;
  logic              otherPulseGenReq;
  logic [2:0]        pulseGenMode;
  gpm_req_t          request;
  logic              pulseGenLevelRun;
  logic              outputDriversMuted;
  logic [3:0]        alarmLatched;
  gpm_inbuf_t        clkInBufCfg;
  gpm_inbuf_t        syncInBufCfg;
  int                n_fail;
  int                n_checks;
  int                cycles;
  // output code table and the pin level each gives with the status below
  localparam logic [4:0] OUT_CODES [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h19, 5'h0C};
  localparam logic [13:0] OUT_VALS = 14'h14AB;
  localparam logic [3:0] IN_CODES [7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h7};
  localparam logic [5:0] IN_REQS [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
  // ****************************************
  // design and partner
  // ****************************************
  gpm_pin_function_mux #(.ALARM_W(4)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .functionInputPin(functionInputPin), .functionOutputPinO(functionOutputPinO),
    .functionOutputPinOe(functionOutputPinOe), .alarmEvents(alarmEvents),
    .status(status), .otherPulseGenReq(otherPulseGenReq), .pulseGenMode(pulseGenMode),
    .request(request), .pulseGenLevelRun(pulseGenLevelRun),
    .outputDriversMuted(outputDriversMuted), .alarmLatched(alarmLatched),
    .clkInBufCfg(clkInBufCfg), .syncInBufCfg(syncInBufCfg));
  gpm_controller_model partner (
    .pinCmd(pinCmd), .functionInputPin(functionInputPin),
    .functionOutputPinO(functionOutputPinO), .functionOutputPinOe(functionOutputPinOe),
    .wireLevel(wireLevel));
  // ****************************************
  // clock, timeout, tasks
  // ****************************************
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr     <= 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 check(regRdData, exp);
  endtask : regRead
  // function is always disabled around a code change
  task automatic pinEvent(input logic [3:0] code, input logic en, input logic [7:0] exp);
    regWrite(8'h46, 8'h00);
    regWrite(8'h46, {3'h0, code, 1'b0});
    if (en)
      regWrite(8'h46, {3'h0, code, 1'b1});
    @(posedge sys_clk);
    pinCmd <= 1'b1;
    @(posedge sys_clk);
    #1 check({request, outputDriversMuted, pulseGenLevelRun}, exp);
    @(posedge sys_clk);
    pinCmd <= 1'b0;
    #1 check({request, outputDriversMuted, pulseGenLevelRun}, exp & 8'hE3);
    repeat (2) @(posedge sys_clk);
  endtask : pinEvent
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    pinCmd = 1'b0;
    alarmEvents = 4'h0;
    status = 10'h2A5;
    otherPulseGenReq = 1'b0;
    pulseGenMode = 3'h0;
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values, spare and unmapped places
    regRead(8'h08, 8'h00);
    regRead(8'h46, 8'h00);
    regRead(8'h50, 8'h00);
    regWrite(8'h05, 8'h5A);
    regRead(8'h05, 8'h00);
    regRead(8'hFF, 8'h00);
    regWrite(8'h08, 8'hA5);
    regRead(8'h08, 8'hA5);
    regWrite(8'h08, 8'h3C);
    regRead(8'h08, 8'h3C);
    // write then read with no gap, data stands one cycle only
    @(posedge sys_clk);
    regAddr   <= 8'h08;
    regWrData <= 8'h96;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 check(regRdData, 8'h96);
    @(posedge sys_clk);
    #1 check(regRdData, 8'h00);
    // one field at a time in each buffer register
    for (int i = 0; i < 5; i++)
    begin
      regWrite(8'h0A, 8'h01 << i);
      regWrite(8'h0B, 8'h10 >> i);
      #1 check({3'h0, clkInBufCfg}, 8'h01 << i);
      check({3'h0, syncInBufCfg}, 8'h10 >> i);
      regRead(8'h0A, 8'h01 << i);
    end
    // alarm latch held across the output tests
    @(posedge sys_clk);
    alarmEvents <= 4'h5;
    @(posedge sys_clk);
    alarmEvents <= 4'h0;
    @(posedge sys_clk);
    #1 check({4'h0, alarmLatched}, 8'h05);
    regRead(8'h0C, 8'h05);
    // every output code, push-pull then open-drain
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 14; i++)
      begin
        regWrite(8'h50, {1'b0, OUT_CODES[i], m[0] ? 1'b0 : 1'b1, 1'b1});
        @(posedge sys_clk);
        #1 check({7'h00, wireLevel}, {7'h00, OUT_VALS[i]});
        check({6'h00, functionOutputPinOe, functionOutputPinO},
              m[0] ? {6'h00, ~OUT_VALS[i], 1'b0} : {6'h00, 1'b1, OUT_VALS[i]});
      end
    regWrite(8'h50, 8'h2A);
    @(posedge sys_clk);
    #1 check({7'h00, functionOutputPinOe}, 8'h00);
    regWrite(8'h06, 8'h01);
    #1 check({4'h0, alarmLatched}, 8'h00);
    // event and clear in one cycle: the event stays latched
    @(posedge sys_clk);
    regAddr     <= 8'h06;
    regWrData   <= 8'h01;
    regWr       <= 1'b1;
    alarmEvents <= 4'h2;
    @(posedge sys_clk);
    regWr       <= 1'b0;
    alarmEvents <= 4'h0;
    #1 check({4'h0, alarmLatched}, 8'h02);
    // input codes while the output stays forced high on the same pin
    regWrite(8'h50, 8'h2B);
    for (int i = 0; i < 7; i++)
      pinEvent(IN_CODES[i], 1'b1, {IN_REQS[i], i == 1, i == 2});
    #1 check({7'h00, functionOutputPinO}, 8'h01);
    pinEvent(4'h2, 1'b0, 8'h00);
    status <= 10'h2A7;
    pinEvent(4'h5, 1'b1, 8'h00);
    status <= 10'h2A5;
    @(posedge sys_clk);
    otherPulseGenReq <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check({7'h00, pulseGenLevelRun}, 8'h01);
    @(posedge sys_clk);
    pulseGenMode <= 3'h1;
    repeat (2) @(posedge sys_clk);
    #1 check({7'h00, pulseGenLevelRun}, 8'h00);
    conclude();
  end
endmodule : gp_pin_function_mux_test

// File: testbench/gpm_controller_model.sv
module gpm_controller_model (
  input  wire logic pinCmd,
  output logic      functionInputPin,
  input  wire logic functionOutputPinO,
  input  wire logic functionOutputPinOe,
  output logic      wireLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin side of the system controller
  // ****************************************
  // controller logic runs on the device clock, so the pin needs no resync
  assign functionInputPin = pinCmd;
  // board pull-up: a released line reads high, never the last driven value
  assign wireLevel = functionOutputPinOe ? functionOutputPinO : 1'b1;
endmodule : gpm_controller_model
